// [core/smrc_pkg.sv]
package smrc_pkg;

    localparam logic [15:0] ADDR_CTRL = 16'hFF50;
    localparam logic [15:0] ADDR_LEVEL = 16'hFF51;
    localparam logic [15:0] ADDR_FLAGS = 16'hFF54;

    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_BELOW_BIT = 0;
    localparam int FLAG_WDT_BIT = 4;
    localparam int FLAG_LVD_BIT = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [3:0] LEVEL_MAX = 4'h9;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int SETTLE_TIME_NS = 200000;
    localparam int SETTLE_CYC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WDT_HOLD_CYC = 8;

    typedef enum logic [3:0]
    {
        ST_POR = 4'h1,
        ST_RUN = 4'h2,
        ST_WDT = 4'h4,
        ST_LVD = 4'h8
    } smrc_state_t;

endpackage : smrc_pkg

// [core/smrc_settle_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module smrc_settle_timer #(
    parameter int CYC = 40000
) (
    input wire logic ref_clk,   // system clock
    input wire logic rst_n,     // async reset
    smrc_tmr_if.tmr tmr         // start/clear and status
);
    logic [16:0] count_r;
    logic done_r;

    assign tmr.busy = (count_r != 17'h00000);
    assign tmr.done = done_r;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= 17'h00000;
            done_r <= 1'b0;
        end
        else if (tmr.clear)
        begin
            count_r <= 17'h00000;
            done_r <= 1'b0;
        end
        else if (tmr.start)
        begin
            count_r <= 17'(CYC);
            done_r <= 1'b0;
        end
        else if (count_r != 17'h00000)
        begin
            count_r <= count_r - 17'h00001;
            done_r <= (count_r == 17'h00001);
        end
    end
endmodule : smrc_settle_timer
`default_nettype wire

// [core/smrc_sync2.sv]
`timescale 1ns/100ps
`default_nettype none
module smrc_sync2 #(
    parameter int W = 2
) (
    input wire logic ref_clk,      // system clock
    input wire logic rst_n,        // async reset
    input wire logic [W-1:0] din,  // asynchronous levels
    output logic [W-1:0] dout      // synchronised levels
);
    logic [W-1:0] stage1_r;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_r <= '0;
            dout <= '0;
        end
        else
        begin
            stage1_r <= din;
            dout <= stage1_r;
        end
    end
endmodule : smrc_sync2
`default_nettype wire

// [core/smrc_tmr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface smrc_tmr_if;
    logic start;
    logic clear;
    logic busy;
    logic done;

    modport ctrl (output start, output clear, input busy, input done);
    modport tmr (input start, input clear, output busy, output done);
endinterface : smrc_tmr_if
`default_nettype wire

// [core/smrc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module smrc_top
    import smrc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic ref_clk,            // system clock, 200 MHz
    input wire logic rst_n,              // external reset / power-up, async
    input wire logic clrBelow,           // clear comparator: supply below threshold
    input wire logic lvdBelow,           // detector comparator: supply below level
    input wire logic wdtResetReq,        // watchdog reset pulse, same clock
    input wire logic [15:0] memAddr,     // register byte address
    input wire logic [7:0] memWdata,     // byte write data
    input wire logic memWrByte,          // whole-byte write strobe
    input wire logic memWrBit,           // single-bit write strobe
    input wire logic [2:0] memBitPos,    // bit number for bit write
    input wire logic memBitVal,          // value for bit write
    input wire logic memRd,              // byte read strobe
    output logic [7:0] memRdata,         // read data, one cycle after strobe
    output logic memRdValid,             // read data valid pulse
    output logic [3:0] levelCode,        // threshold select to comparator
    output logic detectorOn,             // comparator enable
    output logic lowvoltInterrupt,       // interrupt request level
    output logic internalReset,          // internal reset, active high
    output logic detectorSettled,        // settle time elapsed since enable
    output logic clkKeepOn               // request to keep clock running
);

    ////////////////////////////////////////////////////////////////////////////
    // comparator inputs

    logic [1:0] cmpSync;
    logic clrS;
    logic lvdS;

    smrc_sync2 #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({clrBelow, lvdBelow}),
        .dout(cmpSync)
    );

    assign clrS = cmpSync[1];
    assign lvdS = cmpSync[0];

    ////////////////////////////////////////////////////////////////////////////
    // state and registers

    smrc_state_t state_r;
    smrc_state_t state_nxt;
    logic enable_r;
    logic mode_r;
    logic [3:0] level_r;
    logic wdtFlag_r;
    logic lvdFlag_r;
    logic [2:0] hold_r;
    logic enPrev_r;

    logic stPor;
    logic stRun;
    logic stWdt;
    logic stLvd;

    assign stPor = (state_r == ST_POR);
    assign stRun = (state_r == ST_RUN);
    assign stWdt = (state_r == ST_WDT);
    assign stLvd = (state_r == ST_LVD);

    ////////////////////////////////////////////////////////////////////////////
    // detector decode

    logic belowFlag;
    logic lvdReq;
    logic wdtHit;
    logic lvdHit;

    assign belowFlag = enable_r & lvdS;
    assign lvdReq = enable_r & mode_r & lvdS;
    // watchdog wins over detector in the same cycle; clear comparator wins over both
    assign wdtHit = wdtResetReq & ~clrS & ~stPor;
    assign lvdHit = stRun & lvdReq & ~wdtHit & ~clrS;

    assign lowvoltInterrupt = enable_r & ~mode_r & belowFlag;
    assign detectorOn = enable_r;
    assign levelCode = level_r;
    assign internalReset = ~stRun;
    assign clkKeepOn = enable_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic selCtrl;
    logic selLevel;
    logic selFlags;
    logic busOpen;
    logic ctrlByteWr;
    logic ctrlBitWr;
    logic levelWr;
    logic levelLegal;
    logic flagsRead;

    // the core is held in reset outside RUN, so its bus writes are dropped
    assign busOpen = stRun & ~clrS & ~wdtResetReq & ~lvdReq;
    assign selCtrl = (memAddr == ADDR_CTRL);
    assign selLevel = (memAddr == ADDR_LEVEL);
    assign selFlags = (memAddr == ADDR_FLAGS);
    assign ctrlByteWr = busOpen & memWrByte & selCtrl;
    assign ctrlBitWr = busOpen & memWrBit & selCtrl;
    assign levelLegal = (memWdata[3:0] <= LEVEL_MAX);
    // bit writes to the level register are not a supported access
    assign levelWr = busOpen & memWrByte & selLevel & levelLegal;
    assign flagsRead = memRd & selFlags & ~stPor;

    logic enable_wr;
    logic mode_wr;

    // bits 6..2 and bit 0 have no storage, so stray writes vanish
    assign enable_wr = ctrlByteWr ? memWdata[CTRL_EN_BIT] :
                       (ctrlBitWr && memBitPos == 3'(CTRL_EN_BIT)) ? memBitVal : enable_r;
    assign mode_wr = ctrlByteWr ? memWdata[CTRL_MODE_BIT] :
                     (ctrlBitWr && memBitPos == 3'(CTRL_MODE_BIT)) ? memBitVal : mode_r;

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_POR:
            begin
                if (!clrS)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (clrS)
                    state_nxt = ST_POR;
                else if (wdtHit)
                    state_nxt = ST_WDT;
                else if (lvdReq)
                    state_nxt = ST_LVD;
            end
            ST_WDT:
            begin
                if (clrS)
                    state_nxt = ST_POR;
                else if (hold_r == 3'(WDT_HOLD_CYC - 1))
                    state_nxt = ST_RUN;
            end
            ST_LVD:
            begin
                if (clrS)
                    state_nxt = ST_POR;
                else if (wdtHit)
                    state_nxt = ST_WDT;
                else if (!lvdReq)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_POR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_POR;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_r <= 3'h0;
        else if (stWdt)
            hold_r <= hold_r + 3'h1;
        else
            hold_r <= 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and level registers

    logic ctrlClear;

    // every reset source but the detector's own wipes the settings
    assign ctrlClear = clrS | stPor | wdtHit;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_r <= CTRL_RESET[CTRL_EN_BIT];
            mode_r <= CTRL_RESET[CTRL_MODE_BIT];
        end
        else if (ctrlClear)
        begin
            enable_r <= CTRL_RESET[CTRL_EN_BIT];
            mode_r <= CTRL_RESET[CTRL_MODE_BIT];
        end
        else
        begin
            enable_r <= enable_wr;
            mode_r <= mode_wr;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            level_r <= LEVEL_RESET;
        else if (ctrlClear)
            level_r <= LEVEL_RESET;
        else if (levelWr)
            level_r <= memWdata[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset cause flags

    logic wdtFlag_nxt;
    logic lvdFlag_nxt;

    // a cause arriving with a clearing read survives it
    assign wdtFlag_nxt = (clrS | stPor) ? 1'b0 : (wdtHit | (wdtFlag_r & ~flagsRead));
    assign lvdFlag_nxt = (clrS | stPor) ? 1'b0 : (lvdHit | (lvdFlag_r & ~flagsRead));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdtFlag_r <= FLAGS_RESET[FLAG_WDT_BIT];
            lvdFlag_r <= FLAGS_RESET[FLAG_LVD_BIT];
        end
        else
        begin
            wdtFlag_r <= wdtFlag_nxt;
            lvdFlag_r <= lvdFlag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] ctrlView;
    logic [7:0] flagsView;
    logic [7:0] rdMux;

    assign ctrlView = {enable_r, 5'h00, mode_r, belowFlag};
    assign flagsView = {3'h0, wdtFlag_r, 3'h0, lvdFlag_r};
    assign rdMux = selCtrl ? ctrlView :
                   selLevel ? {4'h0, level_r} :
                   selFlags ? flagsView : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            memRdata <= 8'h00;
            memRdValid <= 1'b0;
        end
        else
        begin
            memRdValid <= memRd;
            if (memRd)
                memRdata <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settle timer after enable

    smrc_tmr_if tmrBus ();

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            enPrev_r <= 1'b0;
        else
            enPrev_r <= enable_r;
    end

    assign tmrBus.start = enable_r & ~enPrev_r;
    assign tmrBus.clear = ~enable_r;
    assign detectorSettled = enable_r & tmrBus.done & ~tmrBus.busy;

    smrc_settle_timer #(.CYC(SETTLE_CYCLES)) u_settle (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(tmrBus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_clr_reset;
        clrS |=> internalReset && !enable_r && level_r == LEVEL_RESET;
    endproperty
    a_clr_reset: assert property (p_clr_reset) else $error("reset not held on low supply");

    property p_clr_release;
        (stPor && !clrS) |=> !internalReset;
    endproperty
    a_clr_release: assert property (p_clr_release) else $error("reset not released");

    property p_clr_flags;
        clrS |=> flagsView == FLAGS_RESET;
    endproperty
    a_clr_flags: assert property (p_clr_flags) else $error("flags not cleared by power clear");

    property p_wdt_flag;
        wdtHit |=> wdtFlag_r && lvdFlag_r == ($past(lvdFlag_r) && !$past(flagsRead)) && internalReset;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag wrong");

    property p_wdt_ctrl;
        wdtHit |=> !enable_r && !mode_r;
    endproperty
    a_wdt_ctrl: assert property (p_wdt_ctrl) else $error("control kept after watchdog reset");

    property p_wdt_level;
        wdtHit |=> level_r == LEVEL_RESET;
    endproperty
    a_wdt_level: assert property (p_wdt_level) else $error("level kept after watchdog reset");

    property p_lvd_flag;
        lvdHit |=> lvdFlag_r && stLvd && enable_r && mode_r && level_r == $past(level_r);
    endproperty
    a_lvd_flag: assert property (p_lvd_flag) else $error("detector reset handled wrong");

    property p_lvd_hold;
        (lvdReq && !clrS) |=> internalReset;
    endproperty
    a_lvd_hold: assert property (p_lvd_hold) else $error("reset not held on low level");

    property p_below_read;
        (memRd && selCtrl) |=> memRdValid && memRdata[CTRL_BELOW_BIT] == $past(enable_r && lvdS);
    endproperty
    a_below_read: assert property (p_below_read) else $error("below flag read wrong");

    property p_int_mode;
        lowvoltInterrupt |-> enable_r && !mode_r && stRun;
    endproperty
    a_int_mode: assert property (p_int_mode) else $error("interrupt in wrong mode");

    property p_read_clear;
        (flagsRead && !clrS && !wdtHit && !lvdHit) |=> flagsView == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

    property p_level_bitwr;
        (memWrBit && selLevel && !ctrlClear) |=> level_r == $past(level_r);
    endproperty
    a_level_bitwr: assert property (p_level_bitwr) else $error("bit write changed level");

    property p_level_legal;
        level_r <= LEVEL_MAX;
    endproperty
    a_level_legal: assert property (p_level_legal) else $error("prohibited level stored");

    property p_sync_delay;
        ##2 lvdS == $past(lvdBelow, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser delay wrong");

    c_wdt_reset: cover property (stRun ##1 stWdt ##[1:8] stRun);
    c_lvd_reset: cover property (lvdHit ##1 stLvd ##[1:20] stRun);
    c_interrupt: cover property ($rose(lowvoltInterrupt));
    c_settled: cover property ($rose(detectorSettled));

endmodule : smrc_top
`default_nettype wire

// [test/smrc_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module smrc_top_tb;
    import smrc_pkg::*;

    // short settle count keeps the run brief
    localparam int SETTLE = 20;
    localparam int LIMIT = 3000;

    typedef struct packed {
        logic [15:0] a;
        logic isBit;
        logic [2:0] pos;
        logic [7:0] d;
        logic [7:0] exp;
    } smrc_row_t;

    logic ref_clk;
    logic rst_n;
    logic clrBelow;
    logic lvdBelow;
    logic wdtResetReq;
    logic [15:0] memAddr;
    logic [7:0] memWdata;
    logic memWrByte;
    logic memWrBit;
    logic [2:0] memBitPos;
    logic memBitVal;
    logic memRd;
    logic [7:0] memRdata;
    logic memRdValid;
    logic [3:0] levelCode;
    logic detectorOn;
    logic lowvoltInterrupt;
    logic internalReset;
    logic detectorSettled;
    logic clkKeepOn;
    int n_fail;
    int cmp_count;
    int cycCount = 0;
    smrc_row_t rows [0:10];

    smrc_top #(.SETTLE_CYCLES(SETTLE)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .clrBelow(clrBelow), .lvdBelow(lvdBelow),
        .wdtResetReq(wdtResetReq), .memAddr(memAddr), .memWdata(memWdata),
        .memWrByte(memWrByte), .memWrBit(memWrBit), .memBitPos(memBitPos),
        .memBitVal(memBitVal), .memRd(memRd), .memRdata(memRdata), .memRdValid(memRdValid),
        .levelCode(levelCode), .detectorOn(detectorOn), .lowvoltInterrupt(lowvoltInterrupt),
        .internalReset(internalReset), .detectorSettled(detectorSettled), .clkKeepOn(clkKeepOn)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // hang guard: counts as a mismatch
    always @(posedge ref_clk)
    begin
        cycCount <= cycCount + 1;
        if (cycCount == LIMIT)
        begin
            n_fail++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // every bus task first lets an edge pass, so strobes never toggle twice in one step
    task automatic wrb(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        memAddr = a;
        memWdata = d;
        memWrByte = 1'b1;
        @(negedge ref_clk);
        memWrByte = 1'b0;
    endtask : wrb

    task automatic wrbit(input logic [15:0] a, input logic [2:0] pos, input logic v);
        @(negedge ref_clk);
        memAddr = a;
        memBitPos = pos;
        memBitVal = v;
        memWrBit = 1'b1;
        @(negedge ref_clk);
        memWrBit = 1'b0;
    endtask : wrbit

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        memAddr = a;
        memRd = 1'b1;
        @(negedge ref_clk);
        memRd = 1'b0;
        chk1(memRdValid, 1'b1);
        chk8(memRdata, exp);
    endtask : rd

    task automatic wdtPulse;
        @(negedge ref_clk);
        wdtResetReq = 1'b1;
        @(negedge ref_clk);
        wdtResetReq = 1'b0;
        cyc(1);
        chk1(internalReset, 1'b1);
        cyc(WDT_HOLD_CYC + 4);
        chk1(internalReset, 1'b0);
    endtask : wdtPulse

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clrBelow, lvdBelow, wdtResetReq, memWrByte, memWrBit, memBitVal, memRd} = 7'h00;
        memAddr = 16'h0000;
        memWdata = 8'h00;
        memBitPos = 3'h0;
        n_fail = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        rows = '{
            '{16'hFF51, 1'b0, 3'h0, 8'h09, 8'h09},
            '{16'hFF51, 1'b0, 3'h0, 8'h0A, 8'h09},
            '{16'hFF51, 1'b0, 3'h0, 8'h03, 8'h03},
            '{16'hFF51, 1'b1, 3'h1, 8'h00, 8'h03},
            '{16'hFF50, 1'b0, 3'h0, 8'h82, 8'h82},
            '{16'hFF50, 1'b1, 3'h1, 8'h00, 8'h80},
            '{16'hFF50, 1'b1, 3'h7, 8'h00, 8'h00},
            '{16'hFF50, 1'b1, 3'h7, 8'h01, 8'h80},
            '{16'hFF50, 1'b0, 3'h0, 8'h00, 8'h00},
            '{16'hFF54, 1'b0, 3'h0, 8'hFF, 8'h00},
            '{16'hFF52, 1'b0, 3'h0, 8'h5A, 8'h00}
        };
        cyc(2);
        chk1(internalReset, 1'b1);
        rst_n = 1'b1;
        cyc(3);
        chk1(internalReset, 1'b0);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_LEVEL, 8'h00);
        rd(ADDR_FLAGS, FLAGS_RESET);

        foreach (rows[i])
        begin
            if (rows[i].isBit)
                wrbit(rows[i].a, rows[i].pos, rows[i].d[0]);
            else
                wrb(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].exp);
        end

        // interrupt mode, settle time and sync depth
        wrb(ADDR_CTRL, 8'h80);
        cyc(5);
        chk1(detectorSettled, 1'b0);
        chk1(detectorOn, 1'b1);
        chk1(clkKeepOn, 1'b1);
        cyc(SETTLE);
        chk1(detectorSettled, 1'b1);
        lvdBelow = 1'b1;
        cyc(1);
        chk1(lowvoltInterrupt, 1'b0);
        cyc(1);
        chk1(lowvoltInterrupt, 1'b1);
        chk1(internalReset, 1'b0);
        rd(ADDR_CTRL, 8'h81);
        wrbit(ADDR_CTRL, 3'h7, 1'b0);
        cyc(2);
        chk1(lowvoltInterrupt, 1'b0);
        chk1(clkKeepOn, 1'b0);
        rd(ADDR_CTRL, 8'h00);
        lvdBelow = 1'b0;

        // detector reset holds its own registers
        wrb(ADDR_LEVEL, 8'h05);
        wrb(ADDR_CTRL, 8'h82);
        lvdBelow = 1'b1;
        cyc(4);
        chk1(internalReset, 1'b1);
        lvdBelow = 1'b0;
        cyc(4);
        chk1(internalReset, 1'b0);
        rd(ADDR_CTRL, 8'h82);
        rd(ADDR_LEVEL, 8'h05);
        chk8({4'h0, levelCode}, 8'h05);

        // watchdog on top of a held detector flag
        wdtPulse();
        rd(ADDR_FLAGS, 8'h11);
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        rd(ADDR_LEVEL, 8'h00);

        // clear comparator wipes flags and registers
        wdtPulse();
        wrb(ADDR_LEVEL, 8'h07);
        clrBelow = 1'b1;
        cyc(4);
        chk1(internalReset, 1'b1);
        clrBelow = 1'b0;
        cyc(4);
        chk1(internalReset, 1'b0);
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_LEVEL, 8'h00);

        // external reset in mid-run
        wdtPulse();
        rst_n = 1'b0;
        cyc(2);
        chk1(internalReset, 1'b1);
        rst_n = 1'b1;
        cyc(3);
        rd(ADDR_FLAGS, 8'h00);
        wrap_up();
    end
endmodule : smrc_top_tb
`default_nettype wire
